/* File: inc/iel_defs.vh */
// Constants of the interrupt and activity-output block: register byte
// offsets, field positions and reset values.
// Assumes inclusion by bare name from files under rtl/.
// Functional notes
// - Two 32-bit enable registers exist, one per interrupt line.
// - A 1 in an enable bit lets that source reach its line, a 0 blocks it.
// - A line goes low while any set pending bit has its enable bit at 1.
// - Writing 1s to pending bits clears them and the line goes high when none enabled stay set.
// - A pending bit is set by its event whatever its enable bit holds.
// - Reset-complete and fault flags assert their line even when not enabled.
// - With the merge bit set, line B also goes low for enabled bank A events.
// - With the merge bit set, line A still shows its own enabled bank A events.
// - Pin function code 10 routes the activity output to the shared pin.
// - Sixteen activity sources each have one select bit, all cleared at reset.
// - The activity pin is low while any selected source is active; software cannot force it.
// - Activity sources are not latched; the pin follows their live state.
// - Overcurrent flag is backed by per-phase bits in an overcurrent detail register.
// - No-load flags are backed by per-phase bits in a phase no-load detail register.
// - Reverse power and sum-sign flags are backed by a phase sign detail register.
`ifndef IEL_DEFS_VH
`define IEL_DEFS_VH

//--------------------------------------------------
// Register byte offsets
//--------------------------------------------------
`define IEL_OFS_PEND_A 12'h000
`define IEL_OFS_PEND_B 12'h004
`define IEL_OFS_IEN_A 12'h008
`define IEL_OFS_IEN_B 12'h00c
`define IEL_OFS_CONFIG 12'h010
`define IEL_OFS_ACT_SEL 12'h014
`define IEL_OFS_OC_DET 12'h018
`define IEL_OFS_NL_DET 12'h01c
`define IEL_OFS_SIGN_DET 12'h020
`define IEL_OFS_ACT_LIVE 12'h024

//--------------------------------------------------
// Field positions and codes
//--------------------------------------------------
`define IEL_RST_DONE_BIT 16
`define IEL_FAULT_BIT 18
`define IEL_MERGE_BIT 0
`define IEL_PINF_LSB 1
`define IEL_PINF_MSB 2
`define IEL_PINF_ACTIVITY 2'h2
`define IEL_PINF_READY 2'h1

//--------------------------------------------------
// Reset values
//--------------------------------------------------
`define IEL_IEN_RESET 32'h0000_0000
`define IEL_CONFIG_RESET 3'h0
`define IEL_ACT_SEL_RESET 16'h0000

`endif

/* File: rtl/iel_pending_bank.v */
// One bank of 32 sticky pending bits with write-one-to-clear, plus the
// registered active-low line driven from them.
// Assumes events are one-cycle pulses or levels in the clk domain.
`timescale 1ns/1ps
`default_nettype none
`include "iel_defs.vh"

module iel_pending_bank (
	input wire clk,
	input wire reset_n,
	input wire [31:0] event_in,
	input wire [31:0] clear_mask,
	input wire clear_en,
	input wire [31:0] enable_reg_in,
	input wire [31:0] nonmask_bits,
	input wire extra_req,
	output reg [31:0] pending_reg,
	output wire any_enabled,
	output reg line_n_reg
);
	wire [31:0] clr;
	wire [31:0] pending_next;

	//--------------------------------------------------
	// Sticky bits
	//--------------------------------------------------
	// Zeros in the write leave bits alone; set beats clear
	assign clr = clear_en ? clear_mask : 32'h0000_0000;
	assign pending_next = (pending_reg & ~clr) | event_in;

	// Enabled or nonmaskable bits ask for the line
	assign any_enabled = |(pending_reg & (enable_reg_in | nonmask_bits));

	always @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			pending_reg <= 32'h0000_0000;
			line_n_reg <= 1'b1;
		end else begin
			pending_reg <= pending_next;
			// Registered so the pin never glitches on decode
			line_n_reg <= ~(any_enabled | extra_req);
		end
	end
endmodule

`default_nettype wire

/* File: rtl/iel_activity.v */
// Activity output: masked OR of 16 live sources, no latching.
// Assumes the sources are already synchronous to clk.
`timescale 1ns/1ps
`default_nettype none
`include "iel_defs.vh"

module iel_activity (
	input wire [15:0] sources,
	input wire [15:0] select_reg_in,
	output wire activity_n
);
	wire [15:0] hit;
	genvar i;

	// Per-source gate; the pin tracks sources with no memory
	generate
		for (i = 0; i < 16; i = i + 1) begin : g_src
			assign hit[i] = sources[i] & select_reg_in[i];
		end
	endgenerate

	// Low while any selected source is active
	assign activity_n = ~(|hit);
endmodule

`default_nettype wire

/* File: rtl/iel_top.v */
// Interrupt and activity-output logic with an AXI4-Lite register slave.
// Assumes all event and detail inputs are synchronous to clk.
`timescale 1ns/1ps
`default_nettype none
`include "iel_defs.vh"

module iel_top (
	input wire clk,
	input wire reset_n,
	// AXI4-Lite slave
	input wire [11:0] s_axi_awaddr,
	input wire s_axi_awvalid,
	output wire s_axi_awready,
	input wire [31:0] s_axi_wdata,
	input wire [3:0] s_axi_wstrb,
	input wire s_axi_wvalid,
	output wire s_axi_wready,
	output reg [1:0] s_axi_bresp,
	output reg s_axi_bvalid,
	input wire s_axi_bready,
	input wire [11:0] s_axi_araddr,
	input wire s_axi_arvalid,
	output wire s_axi_arready,
	output reg [31:0] s_axi_rdata,
	output reg [1:0] s_axi_rresp,
	output reg s_axi_rvalid,
	input wire s_axi_rready,
	// Event sources
	input wire [31:0] event_bank_a,
	input wire [31:0] event_bank_b,
	input wire [15:0] activity_sources,
	// Detail inputs and their shared load strobe
	input wire [3:0] overcurrent_per_phase,
	input wire [11:0] phase_noload_in,
	input wire [11:0] phase_sign_in,
	input wire detail_load,
	// Other functions sharing the pin
	input wire pulse_output_four,
	input wire sample_ready_out,
	// Pins
	output wire int_line_a,
	output wire int_line_b,
	output reg shared_pin,
	output wire irq
);
	//--------------------------------------------------
	// Registers
	//--------------------------------------------------
	reg [31:0] interrupt_enable_bank_a_reg;
	reg [31:0] interrupt_enable_bank_b_reg;
	reg [2:0] general_config_reg;
	reg [15:0] act_sel_reg;
	reg [3:0] overcurrent_detail_reg;
	reg [11:0] phase_noload_detail_reg;
	reg [11:0] phase_sign_detail_reg;

	reg aw_held_reg;
	reg w_held_reg;
	reg [11:0] aw_addr_reg;
	reg [31:0] w_data_reg;
	reg [3:0] w_strb_reg;

	wire [31:0] pend_a;
	wire [31:0] pend_b;
	wire a_enabled;
	wire b_enabled;
	wire activity_n;
	wire merge_on;
	wire [1:0] pin_func;
	wire wr_fire;
	wire [11:0] wr_addr;
	wire [31:0] wr_data;
	wire [3:0] wr_strb;
	wire [31:0] strb_mask;
	wire clr_a;
	wire clr_b;
	wire rd_fire;
	wire [31:0] nonmask;

	//--------------------------------------------------
	// Write channel capture
	//--------------------------------------------------
	// Address and data may come in either order; hold each until both
	assign s_axi_awready = ~aw_held_reg & ~s_axi_bvalid;
	assign s_axi_wready = ~w_held_reg & ~s_axi_bvalid;
	assign wr_addr = aw_held_reg ? aw_addr_reg : s_axi_awaddr;
	assign wr_data = w_held_reg ? w_data_reg : s_axi_wdata;
	assign wr_strb = w_held_reg ? w_strb_reg : s_axi_wstrb;
	assign wr_fire = (aw_held_reg | (s_axi_awvalid & s_axi_awready)) &
		(w_held_reg | (s_axi_wvalid & s_axi_wready));
	assign strb_mask = {{8{wr_strb[3]}}, {8{wr_strb[2]}},
		{8{wr_strb[1]}}, {8{wr_strb[0]}}};

	always @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			aw_held_reg <= 1'b0;
			w_held_reg <= 1'b0;
			aw_addr_reg <= 12'h000;
			w_data_reg <= 32'h0000_0000;
			w_strb_reg <= 4'h0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= 2'h0;
		end else begin
			if (wr_fire) begin
				aw_held_reg <= 1'b0;
				w_held_reg <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= 2'h0;
			end else begin
				if (s_axi_awvalid & s_axi_awready) begin
					aw_held_reg <= 1'b1;
					aw_addr_reg <= s_axi_awaddr;
				end
				if (s_axi_wvalid & s_axi_wready) begin
					w_held_reg <= 1'b1;
					w_data_reg <= s_axi_wdata;
					w_strb_reg <= s_axi_wstrb;
				end
				if (s_axi_bvalid & s_axi_bready) begin
					s_axi_bvalid <= 1'b0;
				end
			end
		end
	end

	//--------------------------------------------------
	// Control registers
	//--------------------------------------------------
	// Byte strobes merge the written lanes over the old value
	always @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			interrupt_enable_bank_a_reg <= `IEL_IEN_RESET;
			interrupt_enable_bank_b_reg <= `IEL_IEN_RESET;
			general_config_reg <= `IEL_CONFIG_RESET;
			act_sel_reg <= `IEL_ACT_SEL_RESET;
		end else if (wr_fire) begin
			case (wr_addr)
			`IEL_OFS_IEN_A: begin
				interrupt_enable_bank_a_reg <=
					(interrupt_enable_bank_a_reg & ~strb_mask) |
					(wr_data & strb_mask);
			end
			`IEL_OFS_IEN_B: begin
				interrupt_enable_bank_b_reg <=
					(interrupt_enable_bank_b_reg & ~strb_mask) |
					(wr_data & strb_mask);
			end
			`IEL_OFS_CONFIG: begin
				if (wr_strb[0]) begin
					general_config_reg <= wr_data[2:0];
				end
			end
			`IEL_OFS_ACT_SEL: begin
				act_sel_reg <= (act_sel_reg & ~strb_mask[15:0]) |
					(wr_data[15:0] & strb_mask[15:0]);
			end
			default: begin
			end
			endcase
		end
	end

	//--------------------------------------------------
	// Detail registers
	//--------------------------------------------------
	// Snapshot taken on the shared detail_load strobe so software reads matching detail
	always @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			overcurrent_detail_reg <= 4'h0;
			phase_noload_detail_reg <= 12'h000;
			phase_sign_detail_reg <= 12'h000;
		end else if (detail_load) begin
			overcurrent_detail_reg <= overcurrent_per_phase;
			phase_noload_detail_reg <= phase_noload_in;
			phase_sign_detail_reg <= phase_sign_in;
		end
	end

	//--------------------------------------------------
	// Pending banks and lines
	//--------------------------------------------------
	assign clr_a = wr_fire & (wr_addr == `IEL_OFS_PEND_A);
	assign clr_b = wr_fire & (wr_addr == `IEL_OFS_PEND_B);
	assign merge_on = general_config_reg[`IEL_MERGE_BIT];
	assign pin_func = general_config_reg[`IEL_PINF_MSB:`IEL_PINF_LSB];

	// Reset-complete and fault always reach line B
	assign nonmask = (32'h0000_0001 << `IEL_RST_DONE_BIT) |
		(32'h0000_0001 << `IEL_FAULT_BIT);

	// Line A ignores the merge bit entirely
	iel_pending_bank u_bank_a (
		.clk(clk),
		.reset_n(reset_n),
		.event_in(event_bank_a),
		.clear_mask(wr_data & strb_mask),
		.clear_en(clr_a),
		.enable_reg_in(interrupt_enable_bank_a_reg),
		.nonmask_bits(32'h0000_0000),
		.extra_req(1'b0),
		.pending_reg(pend_a),
		.any_enabled(a_enabled),
		.line_n_reg(int_line_a)
	);

	// Line B also carries enabled bank A events when merged
	iel_pending_bank u_bank_b (
		.clk(clk),
		.reset_n(reset_n),
		.event_in(event_bank_b),
		.clear_mask(wr_data & strb_mask),
		.clear_en(clr_b),
		.enable_reg_in(interrupt_enable_bank_b_reg),
		.nonmask_bits(nonmask),
		.extra_req(merge_on & a_enabled),
		.pending_reg(pend_b),
		.any_enabled(b_enabled),
		.line_n_reg(int_line_b)
	);

	// Single system interrupt is the unregistered OR of both banks' requests, one cycle ahead of the lines
	assign irq = a_enabled | b_enabled;

	//--------------------------------------------------
	// Activity and shared pin
	//--------------------------------------------------
	iel_activity u_act (
		.sources(activity_sources),
		.select_reg_in(act_sel_reg),
		.activity_n(activity_n)
	);

	// Pin mux is combinational so activity stays unlatched
	always @* begin
		case (pin_func)
		`IEL_PINF_ACTIVITY: shared_pin = activity_n;
		`IEL_PINF_READY: shared_pin = sample_ready_out;
		default: shared_pin = pulse_output_four;
		endcase
	end

	//--------------------------------------------------
	// Read channel
	//--------------------------------------------------
	assign s_axi_arready = ~s_axi_rvalid;
	assign rd_fire = s_axi_arvalid & s_axi_arready;

	always @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0000_0000;
			s_axi_rresp <= 2'h0;
		end else if (rd_fire) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rresp <= 2'h0;
			case (s_axi_araddr)
			`IEL_OFS_PEND_A: s_axi_rdata <= pend_a;
			`IEL_OFS_PEND_B: s_axi_rdata <= pend_b;
			`IEL_OFS_IEN_A: s_axi_rdata <= interrupt_enable_bank_a_reg;
			`IEL_OFS_IEN_B: s_axi_rdata <= interrupt_enable_bank_b_reg;
			`IEL_OFS_CONFIG: s_axi_rdata <= {29'h0, general_config_reg};
			`IEL_OFS_ACT_SEL: s_axi_rdata <= {16'h0000, act_sel_reg};
			`IEL_OFS_OC_DET: s_axi_rdata <= {28'h0, overcurrent_detail_reg};
			`IEL_OFS_NL_DET: s_axi_rdata <= {20'h0, phase_noload_detail_reg};
			`IEL_OFS_SIGN_DET: s_axi_rdata <= {20'h0, phase_sign_detail_reg};
			`IEL_OFS_ACT_LIVE: s_axi_rdata <= {16'h0000, activity_sources};
			default: begin
				// Unmapped: decode error, data zero
				s_axi_rdata <= 32'h0000_0000;
				s_axi_rresp <= 2'h3;
			end
			endcase
		end else if (s_axi_rvalid & s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end
endmodule

`default_nettype wire

/* File: verification/iel_checker.sv */
// Assertion checker for iel_top, bound onto its ports.
// Assumes the single clk domain and the async reset_n.
`timescale 1ns/1ps
`default_nettype none
module iel_checker (
	input wire logic clk,
	input wire logic reset_n,
	input wire logic s_axi_awready,
	input wire logic s_axi_wready,
	input wire logic [1:0] s_axi_bresp,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic s_axi_rvalid,
	input wire logic [31:0] event_bank_b,
	input wire logic int_line_a,
	input wire logic int_line_b,
	input wire logic irq
);
	//--------------------
	// Properties
	//--------------------
	// One domain, so clock and reset are given once
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!reset_n);
	line_a_cause_a: assert property (!int_line_a |-> $past(irq))
		else $error("line a low with nothing pending");
	line_b_cause_a: assert property (!int_line_b |-> $past(irq))
		else $error("line b low with nothing pending");
	lines_quiet_a: assert property (!irq |=> int_line_a && int_line_b)
		else $error("line low after pending cleared");
	nonmask_irq_a: assert property (event_bank_b[16] |=> irq)
		else $error("reset flag did not raise irq");
	line_delay_a: assert property (event_bank_b[18] |-> ##2 !int_line_b)
		else $error("fault flag did not pull line b");
	wr_okay_a: assert property (s_axi_bvalid |-> s_axi_bresp == 2'h0)
		else $error("write response not okay");
	wr_block_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
		else $error("write accepted while response pending");
	rd_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read not answered next cycle");
	rd_block_a: assert property (s_axi_rvalid |-> !s_axi_arready)
		else $error("read accepted while data pending");
endmodule
bind iel_top iel_checker u_iel_checker (
	.clk, .reset_n, .s_axi_awready, .s_axi_wready, .s_axi_bresp,
	.s_axi_bvalid, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid,
	.event_bank_b, .int_line_a, .int_line_b, .irq
);
`default_nettype wire

/* File: verification/iel_host_model.sv */
// Host side: watches both interrupt lines and counts alerts.
// Assumes the lines are active-low levels synchronous to clk.
`timescale 1ns/1ps
`default_nettype none
module iel_host_model (
	input wire logic clk,
	input wire logic reset_n,
	input wire logic int_line_a,
	input wire logic int_line_b,
	output logic [7:0] alert_count
);
	//--------------------
	// Alert counter
	//--------------------
	logic low_reg;
	// Counts falls only, so a line held low is one alert
	always @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			low_reg <= 1'b0;
			alert_count <= 8'h00;
		end else begin
			low_reg <= !(int_line_a && int_line_b);
			if (!(int_line_a && int_line_b) && !low_reg)
				alert_count <= alert_count + 8'h01;
		end
	end
endmodule
`default_nettype wire

/* File: verification/tb.sv */
// Self-checking bench for iel_top against a reference model.
// Assumes the register map and one-clock line latency of the design.
`timescale 1ns/1ps
`default_nettype none
module tb;
	//--------------------
	// Signals and model state
	//--------------------
	logic clk = 1'b0, reset_n = 1'b0;
	logic [11:0] s_axi_awaddr = '0, s_axi_araddr = '0;
	logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_arvalid = 1'b0;
	logic s_axi_bready = 1'b1, s_axi_rready = 1'b1, detail_load = 1'b0;
	logic pulse_output_four = 1'b1, sample_ready_out = 1'b0;
	logic [3:0] s_axi_wstrb = 4'hf, overcurrent_per_phase = '0;
	logic [31:0] s_axi_wdata = '0, event_bank_a = '0, event_bank_b = '0;
	logic [15:0] activity_sources = '0;
	logic [11:0] phase_noload_in = '0, phase_sign_in = '0;
	wire s_axi_awready, s_axi_wready, s_axi_bvalid;
	wire s_axi_arready, s_axi_rvalid, int_line_a, int_line_b, shared_pin, irq;
	wire [1:0] s_axi_bresp, s_axi_rresp;
	wire [31:0] s_axi_rdata;
	wire [7:0] alert_count;
	logic [31:0] pa = '0, pb = '0, ea, eb, cfg = '0, sel, m;
	int errors = 0, samples_checked = 0;
	always #20 clk = ~clk;
	iel_top u_iel_top (.clk, .reset_n, .s_axi_awaddr, .s_axi_awvalid,
		.s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
		.s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
		.s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
		.s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .event_bank_a,
		.event_bank_b, .activity_sources, .overcurrent_per_phase,
		.phase_noload_in, .phase_sign_in, .detail_load, .pulse_output_four,
		.sample_ready_out, .int_line_a, .int_line_b, .shared_pin, .irq);
	iel_host_model u_iel_host_model (.clk, .reset_n, .int_line_a,
		.int_line_b, .alert_count);
	//--------------------
	// Model, checks and bus tasks
	//--------------------
	function automatic logic la();
		return |(pa & ea);
	endfunction
	// Merge only folds bank A in; nonmaskables live in bank B
	function automatic logic lb();
		return |(pb & eb) | pb[16] | pb[18] | (cfg[0] & la());
	endfunction
	task chk(input string n, input logic [31:0] s, input logic [31:0] e);
		samples_checked++;
		if (s !== e) begin
			errors++;
			$display("[FAIL] %s expected %h seen %h", n, e, s);
		end
	endtask
	task complete_run;
		if (errors == 0 && samples_checked > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	// Lines are registered, so look one edge after the cause
	task lines;
		@(posedge clk);
		#1;
		chk("int_line_a", int_line_a, !la());
		chk("int_line_b", int_line_b, !lb());
		chk("irq", irq, la() | lb());
	endtask
	task wr(input logic [11:0] a, input logic [31:0] d);
		@(posedge clk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		do begin
			@(posedge clk);
			if (s_axi_awready)
				s_axi_awvalid <= 1'b0;
			if (s_axi_wready)
				s_axi_wvalid <= 1'b0;
		end while (!s_axi_bvalid);
		// Every write, mapped or not, answers OKAY
		chk("bresp", s_axi_bresp, 2'h0);
	endtask
	task rd(input logic [11:0] a, input logic [31:0] e, input logic [1:0] r);
		@(posedge clk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		do begin
			@(posedge clk);
			if (s_axi_arready)
				s_axi_arvalid <= 1'b0;
		end while (!s_axi_rvalid);
		chk("rresp", s_axi_rresp, r);
		if (r == 2'h0)
			chk("rdata", s_axi_rdata, e);
	endtask
	task ev(input logic [31:0] a, input logic [31:0] b);
		@(posedge clk);
		event_bank_a <= a;
		event_bank_b <= b;
		pa = pa | a;
		pb = pb | b;
		@(posedge clk);
		event_bank_a <= '0;
		event_bank_b <= '0;
	endtask
	//--------------------
	// Scenarios
	//--------------------
	// Generous bound of 20000 cycles; a normal run needs well under a thousand
	initial begin
		#(40 * 20000);
		errors++;
		complete_run;
	end
	initial begin
		void'($urandom(26));
		repeat (8) @(posedge clk);
		reset_n <= 1'b1;
		#1 chk("shared_pin", shared_pin, 1'b1);
		rd(12'h008, '0, 2'h0);
		rd(12'h00c, '0, 2'h0);
		rd(12'h014, '0, 2'h0);
		ea = $urandom;
		eb = $urandom;
		wr(12'h008, ea);
		wr(12'h00c, eb);
		rd(12'h008, ea, 2'h0);
		rd(12'h00c, eb, 2'h0);
		// Random events, merge on and off, random partial clears
		repeat (20) begin
			cfg = $urandom & 32'h1;
			wr(12'h010, cfg);
			ev($urandom & $urandom & $urandom, $urandom & $urandom);
			lines;
			m = $urandom;
			wr(12'h000, m);
			pa = pa & ~m;
			m = $urandom;
			wr(12'h004, m);
			pb = pb & ~m;
			rd(12'h000, pa, 2'h0);
			rd(12'h004, pb, 2'h0);
			lines;
		end
		eb = '0;
		wr(12'h00c, eb);
		ev('0, 32'h0005_0000);
		lines;
		// Event held across the clearing write must survive it
		@(posedge clk);
		event_bank_a <= 32'h0000_0008;
		pa = pa | 32'h8;
		wr(12'h000, 32'h0000_0008);
		event_bank_a <= '0;
		rd(12'h000, pa, 2'h0);
		cfg = 32'h4;
		sel = $urandom & 32'hffff;
		wr(12'h010, cfg);
		wr(12'h014, sel);
		rd(12'h014, sel, 2'h0);
		repeat (8) begin
			@(posedge clk);
			activity_sources <= $urandom;
			#1 chk("shared_pin", shared_pin, ~|(activity_sources & sel[15:0]));
		end
		rd(12'h024, {16'h0000, activity_sources}, 2'h0);
		// The other two pin functions, with levels that tell them apart
		cfg = 32'h2;
		wr(12'h010, cfg);
		#1 chk("shared_pin", shared_pin, sample_ready_out);
		cfg = 32'h6;
		wr(12'h010, cfg);
		pulse_output_four <= 1'b0;
		sample_ready_out <= 1'b1;
		#1 chk("shared_pin", shared_pin, pulse_output_four);
		@(posedge clk);
		overcurrent_per_phase <= $urandom;
		phase_noload_in <= $urandom;
		phase_sign_in <= $urandom;
		detail_load <= 1'b1;
		@(posedge clk);
		detail_load <= 1'b0;
		rd(12'h018, {28'h0, overcurrent_per_phase}, 2'h0);
		rd(12'h01c, {20'h0, phase_noload_in}, 2'h0);
		rd(12'h020, {20'h0, phase_sign_in}, 2'h0);
		rd(12'h100, '0, 2'h3);
		chk("alert_count", alert_count != 8'h00, 1'b1);
		// Mid-run reset must bring the lines, the pin and the six registers read back below to idle
		@(posedge clk);
		reset_n <= 1'b0;
		repeat (2) @(posedge clk);
		reset_n <= 1'b1;
		pa = '0;
		pb = '0;
		ea = '0;
		eb = '0;
		cfg = '0;
		#1 chk("shared_pin", shared_pin, pulse_output_four);
		lines;
		rd(12'h000, '0, 2'h0);
		rd(12'h004, '0, 2'h0);
		rd(12'h008, '0, 2'h0);
		rd(12'h010, '0, 2'h0);
		rd(12'h014, '0, 2'h0);
		rd(12'h018, '0, 2'h0);
		complete_run;
	end
endmodule
`default_nettype wire
